/* common/asc_regs.vh */
// register offsets, field positions, reset values and codes of the
// converter configuration register bank; definitions only
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

// ==========================================================
// register offsets (13-bit serial address)
`define ASC_ADDR_W        13
`define ASC_OFFS_PORT_CFG 13'h0000
`define ASC_OFFS_CHIP_IDENTIFIER  13'h0001
`define ASC_OFFS_GRADE    13'h0002
`define ASC_OFFS_INDEX    13'h0005
`define ASC_OFFS_POWER    13'h0008
`define ASC_OFFS_CLOCK    13'h0009
`define ASC_OFFS_CLK_DIV  13'h000B
`define ASC_OFFS_CHOP     13'h000C
`define ASC_OFFS_LOCAL    13'h0010

// ==========================================================
// reset values
`define ASC_RST_PORT_CFG  8'h18
`define ASC_RST_INDEX     8'h33
`define ASC_RST_POWER     2'h0
`define ASC_RST_STAB_ON   1'b0
`define ASC_RST_BYPASS    1'b1
`define ASC_RST_CLK_DIV   3'h0
`define ASC_RST_CHOP      1'b0
`define ASC_RST_LOCAL     8'h00

// ==========================================================
// field positions
`define ASC_CFG_LSB_HI    6
`define ASC_CFG_SRST_HI   5
`define ASC_CFG_SRST_LO   2
`define ASC_CFG_LSB_LO    1
`define ASC_IDX_MASK      8'h33
`define ASC_IDX_CH_A      0
`define ASC_IDX_CH_B      1
`define ASC_IDX_FRAME_CLK 4
`define ASC_IDX_DATA_CLK  5
`define ASC_CLK_STAB_ON   0
`define ASC_CLK_BYPASS    2
`define ASC_CHOP_BIT      2

// ==========================================================
// power state codes
`define ASC_PWR_RUN       2'h0
`define ASC_PWR_DOWN      2'h1
`define ASC_PWR_STANDBY   2'h2
`define ASC_PWR_DIG_RST   2'h3

// ==========================================================
// serial framing counts
`define ASC_INSTR_BITS    4'hF
`define ASC_BYTE_BITS     4'h7

`endif

/* verilog/asc_clk_path.v */
// clock path: divider and duty-cycle stabiliser enable with bypass
// assumes the sample clock is ref_clk; the divided clock leaves as a
// one-cycle tick every ratio+1 cycles
`timescale 1ns/1ps
`default_nettype none

module asc_clk_path
#(
  parameter RATIO_W = 3
)
(
  input  wire               ref_clk,
  input  wire               rst_b,
  input  wire [RATIO_W-1:0] div_ratio,
  input  wire               stab_on,
  input  wire               bypass,
  output reg                clk_tick_r,
  output reg                stab_active_r
);

  reg [RATIO_W-1:0] cnt_r;
  reg [RATIO_W-1:0] cnt_nxt;

  // ==========================================================
  // divider
  always @*
  begin
    cnt_nxt = cnt_r + {{(RATIO_W-1){1'b0}}, 1'b1};
    // ratio change takes effect at once; a count at or above the new ratio wraps on the next clock
    if (bypass || cnt_r >= div_ratio)
      cnt_nxt = {RATIO_W{1'b0}};
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r         <= {RATIO_W{1'b0}};
      clk_tick_r    <= 1'b0;
      stab_active_r <= 1'b0;
    end
    else
    begin
      cnt_r         <= cnt_nxt;
      // bypass routes the input clock past the divider // [RQ8]
      clk_tick_r    <= bypass | (cnt_r >= div_ratio); // [RQ9]
      stab_active_r <= stab_on & ~bypass; // [RQ8]
    end
  end

endmodule

`default_nettype wire

/* verilog/asc_reg_bank.v */
// configuration register bank behind the 3-wire serial control port
// assumes serial_clk, chip_select_bar and the data pin are synchronous
// to ref_clk and that serial_clk runs well below half of ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.vh"

// Overview of operation
// [RQ1] port config reads bits 0 and 7 as 0, bits 3 and 4 as 1
// [RQ2] writing a soft reset bit restores defaults, then the bits clear
// [RQ3] bits 6/1 both select lsb first, bits 5/2 both soft reset
// [RQ4] read-only chip identifier and grade with speed and revision fields
// [RQ5] index register picks units taking local writes; resets to all
// [RQ6] power field: run, full power-down, standby, digital reset
// [RQ7] clock register: bit 0 stabiliser on, bit 2 bypass, bypass at reset
// [RQ8] bypass routes clock around divider and stabiliser
// [RQ9] divide field bits 2:0 selects division by code plus one
// [RQ10] enhancement bit 2 enables chop mode, off at reset
// [RQ11] local registers per unit; reads give channel A if several selected
// [RQ12] host writes zeros to open bits, never unassigned addresses
module asc_reg_bank
#(
  parameter [7:0] CHIP_IDENTIFIER    = 8'hA5, // arbitrary value
  parameter [2:0] SPEED_CODE = 3'h1,  // arbitrary value
  parameter [3:0] REV_CODE   = 4'h1   // arbitrary value
)
(
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire       serial_clk,
  input  wire       chip_select_bar,
  input  wire       serial_io_powerdown_pin_in,
  output reg        serial_io_powerdown_pin_out_r,
  output reg        serial_io_powerdown_pin_oe_r,
  output wire       power_down,
  output wire       standby,
  output wire       digital_reset,
  output wire       clk_tick,
  output wire       stabiliser_active,
  output wire       chop_enable,
  output wire [7:0] local_ch_a,
  output wire [7:0] local_ch_b,
  output wire [7:0] local_frame_clock_out,
  output wire [7:0] local_data_clock_out
);

  // ==========================================================
  // state
  reg                   sclk_q_r;
  reg [15:0]            sh_r;
  reg [15:0]            sh_nxt;
  reg [3:0]             bit_cnt_r;
  reg                   in_data_r;
  reg                   rd_r;
  reg [`ASC_ADDR_W-1:0] addr_r;
  reg [7:0]             tx_r;
  reg                   wr_r;
  reg [`ASC_ADDR_W-1:0] wr_addr_r;
  reg [7:0]             wr_data_r;
  reg                   soft_rst_r;
  reg                   lsb_first_r;
  reg [7:0]             index_r;
  reg [1:0]             power_r;
  reg                   stab_on_r;
  reg                   bypass_r;
  reg [2:0]             clk_div_r;
  reg                   chop_r;
  reg [7:0]             local_r [0:3];
  reg [15:0]            instr;
  reg [7:0]             rx_byte;
  integer               i;

  wire sclk_rise = serial_clk & ~sclk_q_r;
  wire sclk_fall = ~serial_clk & sclk_q_r;
  wire active    = ~chip_select_bar;

  // ==========================================================
  // helpers
  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
        rev8[k] = v[7-k];
    end
  endfunction

  function [15:0] rev16;
    input [15:0] v;
    begin
      rev16 = {rev8(v[7:0]), rev8(v[15:8])};
    end
  endfunction

  // read mux; lowest selected data channel wins for local reads
  function [7:0] rd_byte;
    input [`ASC_ADDR_W-1:0] a;
    begin
      rd_byte = 8'h00;
      if (a == `ASC_OFFS_PORT_CFG)
        rd_byte = {1'b0, lsb_first_r, soft_rst_r, 2'b11,
                   soft_rst_r, lsb_first_r, 1'b0}; // [RQ1] [RQ3]
      else if (a == `ASC_OFFS_CHIP_IDENTIFIER)
        rd_byte = CHIP_IDENTIFIER; // [RQ4]
      else if (a == `ASC_OFFS_GRADE)
        rd_byte = {1'b0, SPEED_CODE, REV_CODE}; // [RQ4]
      else if (a == `ASC_OFFS_INDEX)
        rd_byte = index_r;
      else if (a == `ASC_OFFS_POWER)
        rd_byte = {6'h00, power_r};
      else if (a == `ASC_OFFS_CLOCK)
        rd_byte = {5'h00, bypass_r, 1'b0, stab_on_r};
      else if (a == `ASC_OFFS_CLK_DIV)
        rd_byte = {5'h00, clk_div_r};
      else if (a == `ASC_OFFS_CHOP)
        rd_byte = {5'h00, chop_r, 2'b00};
      else if (a == `ASC_OFFS_LOCAL)
      begin
        if (index_r[`ASC_IDX_CH_A])
          rd_byte = local_r[0]; // [RQ11]
        else if (index_r[`ASC_IDX_CH_B])
          rd_byte = local_r[1];
        else if (index_r[`ASC_IDX_FRAME_CLK])
          rd_byte = local_r[2];
        else if (index_r[`ASC_IDX_DATA_CLK])
          rd_byte = local_r[3];
      end
    end
  endfunction

  // ==========================================================
  // serial framing
  always @*
  begin
    sh_nxt  = {sh_r[14:0], serial_io_powerdown_pin_in};
    instr   = lsb_first_r ? rev16(sh_nxt) : sh_nxt; // [RQ3]
    rx_byte = lsb_first_r ? rev8(sh_nxt[7:0]) : sh_nxt[7:0];
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q_r                      <= 1'b0;
      sh_r                          <= 16'h0000;
      bit_cnt_r                     <= 4'h0;
      in_data_r                     <= 1'b0;
      rd_r                          <= 1'b0;
      addr_r                        <= {`ASC_ADDR_W{1'b0}};
      tx_r                          <= 8'h00;
      wr_r                          <= 1'b0;
      wr_addr_r                     <= {`ASC_ADDR_W{1'b0}};
      wr_data_r                     <= 8'h00;
      serial_io_powerdown_pin_out_r <= 1'b0;
      serial_io_powerdown_pin_oe_r  <= 1'b0;
    end
    else
    begin
      sclk_q_r <= serial_clk;
      wr_r     <= 1'b0;
      if (!active)
      begin
        bit_cnt_r                    <= 4'h0;
        in_data_r                    <= 1'b0;
        serial_io_powerdown_pin_oe_r <= 1'b0;
      end
      else if (sclk_rise && !in_data_r)
      begin
        sh_r      <= sh_nxt;
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == `ASC_INSTR_BITS)
        begin
          // word-count bits are ignored: the frame streams until deselect
          in_data_r <= 1'b1;
          rd_r      <= instr[15];
          addr_r    <= instr[`ASC_ADDR_W-1:0];
          tx_r      <= lsb_first_r ? rev8(rd_byte(instr[12:0]))
                                   : rd_byte(instr[12:0]);
        end
      end
      else if (sclk_rise)
      begin
        sh_r      <= sh_nxt;
        bit_cnt_r <= (bit_cnt_r == `ASC_BYTE_BITS) ? 4'h0
                                                   : bit_cnt_r + 4'h1;
        if (bit_cnt_r == `ASC_BYTE_BITS)
        begin
          // address falls by one per byte in a multibyte frame
          addr_r    <= addr_r - {{(`ASC_ADDR_W-1){1'b0}}, 1'b1};
          wr_r      <= ~rd_r;
          wr_addr_r <= addr_r;
          wr_data_r <= rx_byte;
          tx_r      <= lsb_first_r ? rev8(rd_byte(addr_r - 13'h0001))
                                   : rd_byte(addr_r - 13'h0001);
        end
      end
      else if (sclk_fall && in_data_r && rd_r)
      begin
        // pin turns round on the first fall after the instruction
        serial_io_powerdown_pin_oe_r  <= 1'b1;
        serial_io_powerdown_pin_out_r <= tx_r[7];
        tx_r                          <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // register writes; soft reset overrides any write in its cycle
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      soft_rst_r  <= 1'b0;
      lsb_first_r <= 1'b0;
      index_r     <= `ASC_RST_INDEX;
      power_r     <= `ASC_RST_POWER;
      stab_on_r   <= `ASC_RST_STAB_ON;
      bypass_r    <= `ASC_RST_BYPASS;
      clk_div_r   <= `ASC_RST_CLK_DIV;
      chop_r      <= `ASC_RST_CHOP;
      for (i = 0; i < 4; i = i + 1)
        local_r[i] <= `ASC_RST_LOCAL;
    end
    else if (soft_rst_r)
    begin
      soft_rst_r  <= 1'b0; // [RQ2]
      lsb_first_r <= 1'b0; // [RQ2]
      index_r     <= `ASC_RST_INDEX; // [RQ5]
      power_r     <= `ASC_RST_POWER; // [RQ6]
      stab_on_r   <= `ASC_RST_STAB_ON;
      bypass_r    <= `ASC_RST_BYPASS; // [RQ7]
      clk_div_r   <= `ASC_RST_CLK_DIV; // [RQ9]
      chop_r      <= `ASC_RST_CHOP; // [RQ10]
      for (i = 0; i < 4; i = i + 1)
        local_r[i] <= `ASC_RST_LOCAL;
    end
    else if (wr_r)
    begin
      // open bits are dropped, relying on the host writing zeros // [RQ12]
      if (wr_addr_r == `ASC_OFFS_PORT_CFG)
      begin
        lsb_first_r <= wr_data_r[`ASC_CFG_LSB_HI] |
                       wr_data_r[`ASC_CFG_LSB_LO]; // [RQ3]
        soft_rst_r  <= wr_data_r[`ASC_CFG_SRST_HI] |
                       wr_data_r[`ASC_CFG_SRST_LO]; // [RQ2]
      end
      else if (wr_addr_r == `ASC_OFFS_INDEX)
        index_r <= wr_data_r & `ASC_IDX_MASK; // [RQ5]
      else if (wr_addr_r == `ASC_OFFS_POWER)
        power_r <= wr_data_r[1:0]; // [RQ6]
      else if (wr_addr_r == `ASC_OFFS_CLOCK)
      begin
        stab_on_r <= wr_data_r[`ASC_CLK_STAB_ON]; // [RQ7]
        bypass_r  <= wr_data_r[`ASC_CLK_BYPASS]; // [RQ7]
      end
      else if (wr_addr_r == `ASC_OFFS_CLK_DIV)
        clk_div_r <= wr_data_r[2:0]; // [RQ9]
      else if (wr_addr_r == `ASC_OFFS_CHOP)
        chop_r <= wr_data_r[`ASC_CHOP_BIT]; // [RQ10]
      else if (wr_addr_r == `ASC_OFFS_LOCAL)
      begin
        if (index_r[`ASC_IDX_CH_A])
          local_r[0] <= wr_data_r; // [RQ11]
        if (index_r[`ASC_IDX_CH_B])
          local_r[1] <= wr_data_r; // [RQ11]
        if (index_r[`ASC_IDX_FRAME_CLK])
          local_r[2] <= wr_data_r; // [RQ5]
        if (index_r[`ASC_IDX_DATA_CLK])
          local_r[3] <= wr_data_r; // [RQ5]
      end
    end
  end

  // ==========================================================
  // outputs
  assign power_down    = (power_r == `ASC_PWR_DOWN); // [RQ6]
  assign standby       = (power_r == `ASC_PWR_STANDBY); // [RQ6]
  assign digital_reset = (power_r == `ASC_PWR_DIG_RST); // [RQ6]
  assign chop_enable   = chop_r; // [RQ10]
  assign local_ch_a    = local_r[0];
  assign local_ch_b    = local_r[1];
  assign local_frame_clock_out = local_r[2];
  assign local_data_clock_out  = local_r[3];

  asc_clk_path
  #(
    .RATIO_W (3)
  )
  u_clk_path
  (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .div_ratio     (clk_div_r),
    .stab_on       (stab_on_r),
    .bypass        (bypass_r),
    .clk_tick_r    (clk_tick),
    .stab_active_r (stabiliser_active)
  );

endmodule

`default_nettype wire

/* verification/asc_reg_bank_asserts.sv */
// port checker for the configuration register bank
// assumes one ref_clk domain; bound to asc_reg_bank below
`timescale 1ns/1ps
`default_nettype none
module asc_reg_bank_asserts
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       chip_select_bar,
  input wire logic       serial_io_powerdown_pin_oe_r,
  input wire logic       power_down,
  input wire logic       standby,
  input wire logic       digital_reset,
  input wire logic       clk_tick,
  input wire logic       stabiliser_active,
  input wire logic       chop_enable,
  input wire logic [7:0] local_ch_a
);
  // ==========
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_quiet_in_reset: assert property (disable iff (1'b0)
    !rst_b |-> !serial_io_powerdown_pin_oe_r && !power_down)
    else $error("outputs active in reset");
  a_reset_defaults: assert property ($rose(rst_b) |->
    !chop_enable && !stabiliser_active && local_ch_a == 8'h00)
    else $error("bad values after reset");
  a_tick_first: assert property ($rose(rst_b) |-> ##[0:2] clk_tick)
    else $error("no tick after reset");
  a_tick_alive: assert property (!clk_tick [*7] |-> ##1 clk_tick)
    else $error("divided tick too slow");
  a_mode_onehot: assert property (
    $onehot0({power_down, standby, digital_reset}))
    else $error("several power states");
  a_cfg_in_frame: assert property (($changed(power_down) ||
    $changed(chop_enable) || $changed(local_ch_a) ||
    $changed(stabiliser_active)) |-> !$past(chip_select_bar))
    else $error("setting changed outside a frame");
  a_oe_idle: assert property (
    chip_select_bar [*3] |-> !serial_io_powerdown_pin_oe_r)
    else $error("pin driven while deselected");
  a_oe_start: assert property ($rose(serial_io_powerdown_pin_oe_r) |->
    !chip_select_bar && !$past(chip_select_bar, 3))
    else $error("pin driven too early");
  c_read: cover property (serial_io_powerdown_pin_oe_r);
  c_pdown: cover property (power_down);
  c_stabiliser: cover property (stabiliser_active);
  c_chop: cover property (chop_enable);
endmodule
bind asc_reg_bank asc_reg_bank_asserts u_chk
(
  .ref_clk, .rst_b, .chip_select_bar, .serial_io_powerdown_pin_oe_r,
  .power_down, .standby, .digital_reset, .clk_tick, .stabiliser_active,
  .chop_enable, .local_ch_a
);
`default_nettype wire

/* verification/asc_spi_host.sv */
// serial control port host model, 3-wire, 16-bit instruction
// assumes the bench calls xfer; pins change at ref_clk falling edges
`timescale 1ns/1ps
`default_nettype none
module asc_spi_host
(
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      cs_b,
  output logic      din,
  input  wire logic dout,
  input  wire logic oe
);
  logic lsb = 1'b0;
  logic hd = 1'b0;
  // a released pin shows the inverse of the last bit, not a stale copy
  assign din = oe ? dout : hd;
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
  end
  // ==========
  // one frame: instruction then one data byte
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd,
                      output logic [7:0] rd);
    int k;
    int j;
    rd = 8'h00;
    @(negedge ref_clk) cs_b = 1'b0;
    for (k = 0; k < 24; k++)
    begin
      j = lsb ? k % 8 : 7 - k % 8;
      @(negedge ref_clk) sclk = 1'b0;
      hd = k < 16 ? ins[lsb ? k : 15 - k] : wd[j];
      // low for three cycles leaves room for the device's edge sampling
      repeat (3) @(negedge ref_clk);
      sclk = 1'b1;
      if (k > 15)
        rd[j] = din;
      @(negedge ref_clk);
    end
    @(negedge ref_clk) sclk = 1'b0;
    repeat (4) @(negedge ref_clk);
    cs_b = 1'b1;
    hd = ~hd;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* verification/tb_adc_spi_config_register_bank.sv */
// self-checking bench for the configuration register bank
// assumes asc_spi_host drives the serial pins; checker comes by bind
`timescale 1ns/1ps
`default_nettype none
module tb_adc_spi_config_register_bank;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b1;
  logic       sclk, cs_b, din, dout, oe, pd, sb, dr, tick, stab, chop;
  logic [7:0] la, lb, lf, ld, r;
  int         fails = 0;
  int         compares = 0;
  int         cyc = 0;
  int         g;
  asc_reg_bank DUT
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .serial_clk(sclk),
    .chip_select_bar(cs_b), .serial_io_powerdown_pin_in(din),
    .serial_io_powerdown_pin_out_r(dout),
    .serial_io_powerdown_pin_oe_r(oe), .power_down(pd), .standby(sb),
    .digital_reset(dr), .clk_tick(tick), .stabiliser_active(stab),
    .chop_enable(chop), .local_ch_a(la), .local_ch_b(lb),
    .local_frame_clock_out(lf), .local_data_clock_out(ld)
  );
  asc_spi_host H
  (
    .ref_clk(ref_clk), .sclk(sclk), .cs_b(cs_b), .din(din),
    .dout(dout), .oe(oe)
  );
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end
  // ==========
  // access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    H.xfer({3'b000, a}, d, r);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    H.xfer({3'b100, a}, 8'h00, r);
    chk(r, e);
  endtask
  task automatic gap(output int n);
    for (n = 0; n < 20 && tick !== 1'b1; n++)
      @(negedge ref_clk);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (tick !== 1'b1 && n < 20);
  endtask
  task automatic test_done;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // sequence
  initial
  begin
    // a real falling edge, so the async reset acts before the first clock
    #1 rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    rd(13'h000, 8'h18);
    rd(13'h001, 8'hA5);
    rd(13'h002, 8'h11);
    rd(13'h005, 8'h33);
    rd(13'h008, 8'h00);
    rd(13'h009, 8'h04);
    rd(13'h00B, 8'h00);
    rd(13'h00C, 8'h00);
    wr(13'h001, 8'h00);
    rd(13'h001, 8'hA5);
    for (int m = 0; m < 4; m++)
    begin
      wr(13'h008, {6'h00, m[1:0]});
      chk({5'h00, dr, sb, pd}, m == 0 ? 8'h00 : 8'h01 << (m - 1));
    end
    wr(13'h008, 8'h00);
    wr(13'h005, 8'h02);
    wr(13'h010, 8'h5C);
    chk(lb, 8'h5C);
    chk(la, 8'h00);
    wr(13'h005, 8'h33);
    wr(13'h010, 8'h3D);
    chk(la & lb & lf & ld, 8'h3D);
    chk(la | lb | lf | ld, 8'h3D);
    rd(13'h010, 8'h3D);
    wr(13'h005, 8'h02);
    wr(13'h010, 8'hC3);
    wr(13'h005, 8'h33);
    rd(13'h010, 8'h3D);
    wr(13'h005, 8'h10);
    wr(13'h010, 8'h77);
    chk(lf ^ ld, 8'h4A);
    wr(13'h009, 8'h01);
    wr(13'h00B, 8'h03);
    chk({7'h00, stab}, 8'h01);
    gap(g);
    chk(g[7:0], 8'h04);
    wr(13'h009, 8'h05);
    gap(g);
    chk({g[6:0], stab}, 8'h02);
    wr(13'h00C, 8'h04);
    chk({7'h00, chop}, 8'h01);
    wr(13'h000, 8'h5A);
    H.lsb = 1'b1;
    rd(13'h000, 8'h5A);
    wr(13'h000, 8'h24);
    H.lsb = 1'b0;
    rd(13'h000, 8'h18);
    rd(13'h005, 8'h33);
    rd(13'h00B, 8'h00);
    chk({7'h00, chop}, 8'h00);
    wr(13'h00C, 8'h04);
    wr(13'h000, 8'h1C);
    chk({7'h00, chop}, 8'h00);
    rd(13'h009, 8'h04);
    // second reset in mid-run, with settings away from their defaults
    wr(13'h00B, 8'h05);
    wr(13'h010, 8'h96);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    rd(13'h00B, 8'h00);
    chk(la | lb | lf | ld, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
